// ===== verilog/hb_protect_cfg.svh
// Offsets, field positions, codes and timing figures of the protection monitor.
// Assumes a 100 MHz clock; included by bare name.
`ifndef HB_PROTECT_CFG_SVH
`define HB_PROTECT_CFG_SVH

`define CLK_PERIOD_NS 10
`define BLANK_NS 200
`define OV_DEBOUNCE_US 80
`define UV_DEBOUNCE_MS 40
`define BLANK_CYC ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OV_DEBOUNCE_CYC (`OV_DEBOUNCE_US * 1000 / `CLK_PERIOD_NS)
`define UV_DEBOUNCE_CYC (`UV_DEBOUNCE_MS * 1000000 / `CLK_PERIOD_NS)

`define REG_STATUS 8'h00
`define REG_CTRL 8'h04
`define REG_EVENT 8'h08
`define REG_GATE 8'h0C

`define CTRL_LATCH_RESET_BIT 0
`define EVENT_PENDING_BIT 0

`define SYS_NONE 3'h0
`define SYS_OV 3'h4
`define SYS_UV100 3'h2
`define SYS_UV85 3'h6
`define SYS_UV70 3'h1
`define SYS_UV55 3'h5
`define SYS_THERMAL 3'h3
`define SYS_LS_NOT_READY 3'h7

`define DEV_NONE 2'h0
`define DEV_WARNING 2'h2
`define DEV_SHUTDOWN 2'h1
`define DEV_HS_NOT_READY 2'h3

`define IN_LS_CMD 0
`define IN_HS_CMD_N 1
`define IN_LS_OC 2
`define IN_HS_OC 3
`define IN_LS_SHORT 4
`define IN_HS_SHORT 5
`define IN_TEMP_WARN 6
`define IN_TEMP_SD 7
`define IN_MON_STRAP 8
`define IN_ABOVE_OV 9
`define IN_BELOW_HYST 10
`define IN_UV1 11
`define IN_SYS_THERMAL 15

`define STRAP_WAIT 2'h2

`endif

// ===== verilog/hb_protect_pkg.sv
// Types of the protection monitor: undervoltage level and the state record.
// Widths here must match the counts in hb_protect_cfg.svh.
package hb_protect_pkg;

   localparam int SYNC_W = 16;

   typedef enum logic [2:0] {
      UV_NONE = 3'b000,
      UV_L1 = 3'b001,
      UV_L2 = 3'b010,
      UV_L3 = 3'b011,
      UV_L4 = 3'b100
   } uv_level_t;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic bus_mode;
      logic [1:0] cmd_prev;
      logic [1:0] on;
      logic [1:0] oc_wait;
      logic [1:0][7:0] blank_cnt;
      logic therm_latch;
      logic ov;
      logic [15:0] ov_cnt;
      uv_level_t uv_lvl;
      uv_level_t uv_cand;
      logic [23:0] uv_cnt;
      logic [6:0] status;
      logic upd;
      logic pend;
      logic bus_act;
      logic bus_wr;
      logic [7:0] bus_addr;
      logic [31:0] rdata;
   } state_t;

endpackage

// ===== verilog/half_bridge_protection_monitor.sv
// Protection and supervision logic of a self-powered half-bridge driver.
// Assumes analog comparators and pins outside; all of them are asynchronous.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "hb_protect_cfg.svh"

// Overview of operation
// - Over-current after blanking turns that switch off
// - Re-arm needs off edge then on edge
// - Over-current sets matching status flag
// - Shorted low limit resistor disables switching, reports not-ready
// - High-side short leaves low-side commands working
// - Thermal warning reported, switching continues
// - Thermal shutdown latches both switches off
// - Monitoring and reporting continue during shutdown
// - Shutdown clears by reset command or power-up
// - Monitor input mode captured once at power-up
// - Four undervoltage levels and one overvoltage level
// - Any undervoltage or overvoltage gives bus fault
// - Undervoltage reported after 40 ms persistence
// - Undervoltage clearing also debounced 40 ms
// - Recovery reports deepest level still crossed
// - Overvoltage for 80 us ends on-time
// - Overvoltage ignores turn-on until hysteresis debounced
// - Overvoltage clearing sends further update
// - System faults coded in status bits 0-2
// - Bits 3-4 device thermal or HS not-ready, 5-6 over-current
module half_bridge_protection_monitor #(
   parameter int unsigned OV_DEBOUNCE_CYC = `OV_DEBOUNCE_CYC,
   parameter int unsigned UV_DEBOUNCE_CYC = `UV_DEBOUNCE_CYC
) (
   input wire logic clk_i, // 100 MHz clock
   input wire logic rst_n_i, // Async reset, power-up
   input wire logic hsel_i, // AHB select
   input wire logic [31:0] haddr_i, // AHB address
   input wire logic [1:0] htrans_i, // AHB transfer type
   input wire logic hwrite_i, // AHB write
   input wire logic [2:0] hsize_i, // AHB size, word only
   input wire logic [31:0] hwdata_i, // AHB write data
   input wire logic hready_i, // AHB bus ready
   output logic [31:0] hrdata_o, // AHB read data
   output logic hreadyout_o, // AHB slave ready
   output logic hresp_o, // AHB response, always OKAY
   input wire logic low_side_on_cmd_i, // Low-side control, high = on
   input wire logic high_side_on_cmd_n_i, // High-side control, low = on
   input wire logic ls_overcurrent_i, // Low-side current above limit
   input wire logic hs_overcurrent_i, // High-side current above limit
   input wire logic low_limit_prog_short_i, // Low limit resistor below 35k
   input wire logic high_limit_prog_short_i, // High limit resistor below 35k
   input wire logic thermal_warning_level_i, // Low-side FET at warning level
   input wire logic thermal_shutdown_level_i, // Low-side FET above shutdown
   input wire logic monitor_bus_wired_i, // Monitor input wired for bus sense
   input wire logic sm_above_ov_i, // Monitor current above OV level
   input wire logic sm_below_ov_hyst_i, // Monitor current below OV - hyst
   input wire logic [3:0] sm_below_uv_i, // Below level 1..4 (100..55 %)
   input wire logic sm_thermistor_hot_i, // Thermistor below trip voltage
   output logic ls_gate_o, // Low-side switch on
   output logic hs_gate_o, // High-side switch on
   output logic [6:0] status_word_o, // Encoded status word
   output logic status_update_o // Status update request pulse
);

   localparam logic [7:0] BLANK_LIM = 8'(`BLANK_CYC);
   localparam logic [15:0] OV_LIM = 16'(OV_DEBOUNCE_CYC - 1);
   localparam logic [23:0] UV_LIM = 24'(UV_DEBOUNCE_CYC - 1);

   hb_protect_pkg::state_t q;
   hb_protect_pkg::state_t n;

   logic [hb_protect_pkg::SYNC_W-1:0] pins;
   logic [1:0] cmd;
   logic [1:0] oc_in;
   logic [1:0] kill;
   logic [1:0] rise;
   logic [1:0] fall;
   logic addr_phase;
   logic ctrl_wr;
   logic event_wr;
   hb_protect_pkg::uv_level_t uv_raw;
   logic [2:0] sys_code;
   logic [1:0] dev_code;
   logic [6:0] status_new;
   logic ov_cond;

   assign pins = {sm_thermistor_hot_i, sm_below_uv_i, sm_below_ov_hyst_i, sm_above_ov_i,
                  monitor_bus_wired_i, thermal_shutdown_level_i, thermal_warning_level_i,
                  high_limit_prog_short_i, low_limit_prog_short_i, hs_overcurrent_i,
                  ls_overcurrent_i, high_side_on_cmd_n_i, low_side_on_cmd_i};

   always_comb begin
      n = q;
      n.s1 = pins;
      n.s2 = q.s1;
      cmd[0] = q.s2[`IN_LS_CMD];
      cmd[1] = ~q.s2[`IN_HS_CMD_N];
      oc_in[0] = q.s2[`IN_LS_OC];
      oc_in[1] = q.s2[`IN_HS_OC];
      rise = cmd & ~q.cmd_prev;
      fall = ~cmd & q.cmd_prev;
      n.cmd_prev = cmd;

      // Bus write decode in the data phase
      ctrl_wr = q.bus_act && q.bus_wr && (q.bus_addr == `REG_CTRL)
                && hwdata_i[`CTRL_LATCH_RESET_BIT];
      event_wr = q.bus_act && q.bus_wr && (q.bus_addr == `REG_EVENT)
                 && hwdata_i[`EVENT_PENDING_BIT];

      // Mode strap sampled once the synchroniser has settled
      if (!q.strap_done) begin
         if (q.strap_cnt == `STRAP_WAIT) begin
            n.strap_done = 1'b1;
            n.bus_mode = q.s2[`IN_MON_STRAP];
         end else begin
            n.strap_cnt = q.strap_cnt + 2'h1;
         end
      end

      // Set wins over the reset command while still too hot
      if (ctrl_wr) begin
         n.therm_latch = 1'b0;
      end
      if (q.s2[`IN_TEMP_SD]) begin
         n.therm_latch = 1'b1;
      end

      // Overvoltage: enter on above-OV, leave on below OV minus hysteresis
      ov_cond = q.ov ? q.s2[`IN_BELOW_HYST] : q.s2[`IN_ABOVE_OV];
      if (!q.bus_mode) begin
         n.ov = 1'b0;
         n.ov_cnt = 16'h0000;
      end else if (!ov_cond) begin
         n.ov_cnt = 16'h0000;
      end else if (q.ov_cnt == OV_LIM) begin
         n.ov = ~q.ov;
         n.ov_cnt = 16'h0000;
      end else begin
         n.ov_cnt = q.ov_cnt + 16'h0001;
      end

      // Deepest undervoltage level currently crossed
      if (q.s2[`IN_UV1 + 3]) begin
         uv_raw = hb_protect_pkg::UV_L4;
      end else if (q.s2[`IN_UV1 + 2]) begin
         uv_raw = hb_protect_pkg::UV_L3;
      end else if (q.s2[`IN_UV1 + 1]) begin
         uv_raw = hb_protect_pkg::UV_L2;
      end else if (q.s2[`IN_UV1]) begin
         uv_raw = hb_protect_pkg::UV_L1;
      end else begin
         uv_raw = hb_protect_pkg::UV_NONE;
      end

      // Level moves only after the new level has held for the whole time
      if (!q.bus_mode || uv_raw == q.uv_lvl) begin
         n.uv_cnt = 24'h000000;
         n.uv_cand = q.uv_lvl;
      end else if (uv_raw != q.uv_cand) begin
         n.uv_cand = uv_raw;
         n.uv_cnt = 24'h000000;
      end else if (q.uv_cnt == UV_LIM) begin
         n.uv_lvl = uv_raw;
         n.uv_cnt = 24'h000000;
      end else begin
         n.uv_cnt = q.uv_cnt + 24'h000001;
      end

      // Gate control, index 0 low side, 1 high side
      kill[0] = !q.strap_done || q.therm_latch || q.ov
                || q.s2[`IN_LS_SHORT];
      kill[1] = !q.strap_done || q.therm_latch || q.ov
                || q.s2[`IN_LS_SHORT] || q.s2[`IN_HS_SHORT];
      for (int i = 0; i < 2; i++) begin
         if (q.on[i] && q.blank_cnt[i] != BLANK_LIM) begin
            n.blank_cnt[i] = q.blank_cnt[i] + 8'h01;
         end
         if (fall[i]) begin
            n.on[i] = 1'b0;
            n.oc_wait[i] = 1'b0;
         end else if (rise[i] && !kill[i] && !q.oc_wait[i] && !q.on[1 - i]) begin
            n.on[i] = 1'b1;
            n.blank_cnt[i] = 8'h00;
         end else if (q.on[i] && q.blank_cnt[i] == BLANK_LIM && oc_in[i]) begin
            n.on[i] = 1'b0;
            n.oc_wait[i] = 1'b1;
         end
         if (kill[i]) begin
            n.on[i] = 1'b0;
         end
      end

      // System-level code, shorted low limit resistor first
      if (q.s2[`IN_LS_SHORT]) begin
         sys_code = `SYS_LS_NOT_READY;
      end else if (!q.bus_mode) begin
         sys_code = q.s2[`IN_SYS_THERMAL] ? `SYS_THERMAL : `SYS_NONE;
      end else if (q.ov) begin
         sys_code = `SYS_OV;
      end else begin
         case (q.uv_lvl)
            hb_protect_pkg::UV_L1: sys_code = `SYS_UV100;
            hb_protect_pkg::UV_L2: sys_code = `SYS_UV85;
            hb_protect_pkg::UV_L3: sys_code = `SYS_UV70;
            hb_protect_pkg::UV_L4: sys_code = `SYS_UV55;
            default: sys_code = `SYS_NONE;
         endcase
      end

      if (q.therm_latch) begin
         dev_code = `DEV_SHUTDOWN;
      end else if (q.s2[`IN_HS_SHORT]) begin
         dev_code = `DEV_HS_NOT_READY;
      end else if (q.s2[`IN_TEMP_WARN]) begin
         dev_code = `DEV_WARNING;
      end else begin
         dev_code = `DEV_NONE;
      end

      // Field order of the word: [2:0] system, [4:3] device, [5] LS, [6] HS
      status_new = {q.oc_wait[1], q.oc_wait[0], dev_code, sys_code};
      // Word held at zero until setup, so the first nonzero word is reported
      if (q.strap_done) begin
         n.status = status_new;
      end
      n.upd = q.strap_done && (status_new != q.status);
      if (event_wr) begin
         n.pend = 1'b0;
      end
      if (q.upd) begin
         n.pend = 1'b1;
      end

      // AHB-Lite slave, zero wait states, read data registered
      addr_phase = hsel_i && hready_i && htrans_i[1];
      n.bus_act = addr_phase;
      n.bus_wr = hwrite_i;
      n.bus_addr = haddr_i[7:0];
      n.rdata = 32'h00000000;
      if (addr_phase && !hwrite_i) begin
         case (haddr_i[7:0])
            `REG_STATUS: n.rdata = {14'h0000, q.strap_done, q.therm_latch, 3'h0, q.uv_lvl,
                                    q.ov, q.bus_mode, 1'b0, q.status};
            `REG_EVENT: n.rdata = {31'h00000000, q.pend};
            `REG_GATE: n.rdata = {28'h0000000, q.oc_wait, q.on};
            default: n.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign hrdata_o = q.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign ls_gate_o = q.on[0];
   assign hs_gate_o = q.on[1];
   assign status_word_o = q.status;
   assign status_update_o = q.upd;

endmodule

// ===== dv/hb_protect_monitor.sv
// Checker for the protection monitor, bound to its top module.
// Assumes shortened debounce counts in simulation.
`timescale 1ns/1ps
module hb_protect_monitor (
   input wire logic clk_i, // Clock
   input wire logic rst_n_i, // Async reset
   input wire logic low_side_on_cmd_i, // LS command
   input wire logic ls_overcurrent_i, // LS over-current
   input wire logic low_limit_prog_short_i, // LS limit short
   input wire logic high_limit_prog_short_i, // HS limit short
   input wire logic thermal_shutdown_level_i, // Shutdown level
   input wire logic ls_gate_o, // LS gate
   input wire logic hs_gate_o, // HS gate
   input wire logic [6:0] status_word_o, // Status word
   input wire logic status_update_o // Update pulse
);
   logic [4:0] on_cnt_q;
   logic [4:0] on_cnt_d;
   // Saturating on-time, so blanking is surely over at 24
   always_comb on_cnt_d = !ls_gate_o ? 5'h00 : on_cnt_q + {4'h0, on_cnt_q != 5'h1F};
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) on_cnt_q <= 5'h00;
      else on_cnt_q <= on_cnt_d;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_ls_oc;
      on_cnt_q >= 5'h18 && ls_overcurrent_i |-> ##[1:5] !ls_gate_o;
   endproperty
   a_ls_oc: assert property (p_ls_oc) else $error("gate on under over-current");
   property p_rearm;
      low_side_on_cmd_i[*4] ##0 $fell(ls_gate_o) ##1 low_side_on_cmd_i[*8] |-> !ls_gate_o;
   endproperty
   a_rearm: assert property (p_rearm) else $error("gate back on without edges");
   property p_oc_flag;
      $fell(ls_gate_o) && ls_overcurrent_i |-> ##[0:3] status_word_o[5];
   endproperty
   a_oc_flag: assert property (p_oc_flag) else $error("over-current flag missing");
   property p_upd;
      status_update_o == (status_word_o != $past(status_word_o));
   endproperty
   a_upd: assert property (p_upd) else $error("update pulse wrong");
   property p_sd_off;
      thermal_shutdown_level_i[*6] |-> !ls_gate_o && !hs_gate_o;
   endproperty
   a_sd_off: assert property (p_sd_off) else $error("gate on in shutdown");
   property p_sd_code;
      thermal_shutdown_level_i[*7] |-> status_word_o[4:3] == 2'h1;
   endproperty
   a_sd_code: assert property (p_sd_code) else $error("shutdown code wrong");
   property p_ov_block;
      (status_word_o[2:0] == 3'h4)[*3] |-> !ls_gate_o && !hs_gate_o;
   endproperty
   a_ov_block: assert property (p_ov_block) else $error("gate on in overvoltage");
   property p_ls_short;
      low_limit_prog_short_i[*6] |-> !ls_gate_o && !hs_gate_o;
   endproperty
   a_ls_short: assert property (p_ls_short) else $error("gate on, LS short");
   property p_hs_short;
      high_limit_prog_short_i[*6] |-> !hs_gate_o;
   endproperty
   a_hs_short: assert property (p_hs_short) else $error("gate on, HS short");
   c_oc: cover property (status_update_o && status_word_o[5]);
   c_ov: cover property (status_word_o[2:0] == 3'h4);
   c_sd: cover property (status_word_o[4:3] == 2'h1);
endmodule
bind half_bridge_protection_monitor hb_protect_monitor u_hb_protect_monitor (.clk_i, .rst_n_i,
   .low_side_on_cmd_i, .ls_overcurrent_i, .low_limit_prog_short_i, .high_limit_prog_short_i,
   .thermal_shutdown_level_i, .ls_gate_o, .hs_gate_o, .status_word_o, .status_update_o);

// ===== dv/mcu_gate_model.sv
// Controller model driving the two gate command pins.
// Assumes the bench clock; edges are launched just after a rising edge.
`timescale 1ns/1ps
module mcu_gate_model (
   input wire logic clk_i, // Bench clock
   output logic low_side_on_cmd_o, // LS on, high active
   output logic high_side_on_cmd_n_o // HS on, low active
);
   // Idle levels match the pin pulls: both switches off
   initial begin
      low_side_on_cmd_o = 1'b0;
      high_side_on_cmd_n_o = 1'b1;
   end
   task automatic cmd(input int side, input logic on);
      @(posedge clk_i);
      if (side == 0) low_side_on_cmd_o <= on;
      else high_side_on_cmd_n_o <= !on;
   endtask
endmodule

// ===== dv/half_bridge_protection_monitor_tb.sv
// Self-checking bench: bus reads, gate commands and status updates.
// Assumes shortened debounce parameters and bus-sense strap.
`timescale 1ns/1ps
module half_bridge_protection_monitor_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, wired = 1'b1, ov_hi = 1'b0, hyst_lo = 1'b1;
   logic [1:0] htrans = 2'h0, oc = 2'h0, shrt = 2'h0, therm = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [3:0] uv = 4'h0;
   logic [2:0] hsize = 3'h0;
   logic hot = 1'b0;
   logic [6:0] status;
   logic hready, hresp, upd, ls_cmd, hs_cmd_n, ls_gate, hs_gate;
   int mismatches = 0, n_tests = 0;
   logic [31:0] q[$];
   always #5 clk_i = ~clk_i;
   half_bridge_protection_monitor #(.OV_DEBOUNCE_CYC(8), .UV_DEBOUNCE_CYC(16))
   u_half_bridge_protection_monitor (.clk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .low_side_on_cmd_i(ls_cmd),
      .high_side_on_cmd_n_i(hs_cmd_n), .ls_overcurrent_i(oc[0]), .hs_overcurrent_i(oc[1]),
      .low_limit_prog_short_i(shrt[0]), .high_limit_prog_short_i(shrt[1]),
      .thermal_warning_level_i(therm[0]), .thermal_shutdown_level_i(therm[1]),
      .monitor_bus_wired_i(wired), .sm_above_ov_i(ov_hi), .sm_below_ov_hyst_i(hyst_lo),
      .sm_below_uv_i(uv), .sm_thermistor_hot_i(hot), .ls_gate_o(ls_gate), .hs_gate_o(hs_gate),
      .status_word_o(status), .status_update_o(upd));
   mcu_gate_model u_mcu_gate_model (.clk_i, .low_side_on_cmd_o(ls_cmd),
      .high_side_on_cmd_n_o(hs_cmd_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic rdy;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (hready === 1'b1) return;
      end
      mismatches++;
      wrap_up();
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= 2'h2;
      hsel <= 1'b1;
      rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      rdy();
      rd = hrdata;
      hwdata <= 32'h0;
   endtask
   task automatic gates(input logic [31:0] exp);
      chk({30'h0, hs_gate, ls_gate}, exp);
   endtask
   // Every update pulse must match the oldest expected word
   always @(posedge clk_i) begin
      if (upd === 1'b1) chk({25'h0, status}, q.size() > 0 ? q.pop_front() : 32'hFFFF_FFFF);
   end
   initial begin
      void'($urandom(54));
      w(16);
      rst_n_i <= 1'b1;
      w(6);
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h0002_0100);
      chk({30'h0, hresp, hready}, 32'h1);
      bus(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 32'hC, 32'hF);
      bus(1'b0, 32'hC, 32'h0);
      chk(rd, 32'h0);
      wired <= 1'b0;
      // Thermistor input has no effect once bus sensing is locked in
      hot <= 1'($urandom);
      for (int i = 0; i < 2; i++) begin
         u_mcu_gate_model.cmd(i, 1'b1);
         w(25 + int'($urandom % 8));
         oc[i] <= 1'b1;
         q.push_back(32'h20 << i);
         w(8);
         gates(32'h0);
         oc[i] <= 1'b0;
         u_mcu_gate_model.cmd(i, 1'b0);
         q.push_back(32'h0);
         w(6);
         u_mcu_gate_model.cmd(i, 1'b1);
         w(5);
         gates(32'h1 << i);
         u_mcu_gate_model.cmd(i, 1'b0);
         w(6);
      end
      u_mcu_gate_model.cmd(0, 1'b1);
      w(5);
      therm <= 2'h1;
      q.push_back(32'h10);
      w(6);
      gates(32'h1);
      therm <= 2'h3;
      q.push_back(32'h08);
      w(8);
      gates(32'h0);
      therm <= 2'h0;
      uv <= 4'h1;
      q.push_back(32'h0A);
      w(24);
      uv <= 4'h7;
      q.push_back(32'h09);
      w(24);
      uv <= 4'h3;
      q.push_back(32'h0E);
      w(24);
      uv <= 4'h0;
      q.push_back(32'h08);
      w(24);
      uv <= 4'hF;
      w(1 + int'($urandom % 10));
      uv <= 4'h0;
      w(24);
      u_mcu_gate_model.cmd(0, 1'b0);
      bus(1'b1, 32'h4, 32'h1);
      q.push_back(32'h0);
      w(6);
      u_mcu_gate_model.cmd(0, 1'b1);
      w(5);
      ov_hi <= 1'b1;
      hyst_lo <= 1'b0;
      q.push_back(32'h4);
      w(20);
      gates(32'h0);
      u_mcu_gate_model.cmd(0, 1'b0);
      w(4);
      u_mcu_gate_model.cmd(0, 1'b1);
      w(6);
      gates(32'h0);
      u_mcu_gate_model.cmd(0, 1'b0);
      ov_hi <= 1'b0;
      hyst_lo <= 1'b1;
      q.push_back(32'h0);
      w(20);
      shrt <= 2'h2;
      q.push_back(32'h18);
      w(8);
      u_mcu_gate_model.cmd(0, 1'b1);
      w(5);
      gates(32'h1);
      u_mcu_gate_model.cmd(0, 1'b0);
      w(5);
      u_mcu_gate_model.cmd(1, 1'b1);
      w(5);
      gates(32'h0);
      u_mcu_gate_model.cmd(1, 1'b0);
      shrt <= 2'h0;
      q.push_back(32'h0);
      w(8);
      shrt <= 2'h1;
      q.push_back(32'h07);
      u_mcu_gate_model.cmd(0, 1'b1);
      w(6);
      gates(32'h0);
      u_mcu_gate_model.cmd(0, 1'b0);
      shrt <= 2'h0;
      q.push_back(32'h0);
      w(8);
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h0002_0100);
      chk(32'(q.size()), 32'h0);
      wrap_up();
   end
endmodule
